/* File: bench/host_port_model.sv */
// Behavioural model of the switch's asynchronous parallel host port.
// Assumes controller pins wired straight in and one resolved data bus.
`timescale 1ns/1ps

module host_port_model (
    // Reset and straps
    input wire logic rst_n_i,
    input wire logic mux_i,
    input wire logic width_i,
    input wire logic endian_i,
    // Strobes and address
    input wire logic cs_n_i,
    input wire logic wnr_i,
    input wire logic oe_n_i,
    input wire logic ale_a2_i,
    input wire logic [15:3] addr_i,
    // Data bus, drive enables for lower and upper half
    input wire logic [31:0] bus_i,
    output logic [31:0] dout_o,
    output logic [1:0] doe_o,
    // Internal events and interrupt lines
    input wire logic [2:0] ev_i,
    output logic [2:0] irq_o
);
    logic mux_r;
    logic wide_r;
    logic le_r;
    logic [15:2] a_r;
    logic [31:0] mem [0:15];

    // ========================================
    // Straps count only at the moment reset lets go
    always @(posedge rst_n_i) begin
        mux_r = mux_i;
        wide_r = width_i;
        le_r = endian_i;
    end

    // Dedicated lines at chip select fall; they are unused when muxed
    always @(negedge cs_n_i) begin
        if (!mux_r) a_r = {addr_i, ale_a2_i};
    end
    always @(negedge ale_a2_i) begin
        if (mux_r) a_r = bus_i[15:2];
    end

    // Write commits as chip select rises; word index only, no byte lanes
    always @(posedge cs_n_i) begin
        if (!wnr_i) mem[a_r[5:2]] = bus_i;
    end

    // Drive only in a read with output enable low; narrow bus leaves top
    assign doe_o[0] = !oe_n_i && !cs_n_i && wnr_i;
    assign doe_o[1] = doe_o[0] && wide_r;
    assign dout_o = mem[a_r[5:2]];
    // Event selection is left to the bench, one line per event set
    assign irq_o = ev_i;
endmodule

/* File: bench/parallel_host_bus_interface_bench.sv */
// Self-checking bench: APB tasks drive the controller against the model.
// Assumes the controller and the host port model compiled before it.
`timescale 1ns/1ps

module parallel_host_bus_interface_bench;
    logic clk_i;
    logic nrst_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_o;
    logic dev_rst_n_o;
    logic mux_s;
    logic width_s;
    logic endian_s;
    logic cs_n_o;
    logic wnr_o;
    logic oe_n_o;
    logic la_o;
    logic [15:3] addr_o;
    logic [31:0] data_o;
    logic data_oe_o;
    logic [31:0] bus;
    logic [31:0] dout;
    logic [1:0] doe;
    logic [31:0] idle_r;
    logic [2:0] ev;
    logic [2:0] dev_irq;
    logic [31:0] rd;
    logic er;
    logic [31:0] cfg;
    logic [15:0] tbl [4];
    int failures = 0;
    int comparisons = 0;

    phb_host_ctrl phb_host_ctrl_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
        .dev_rst_n_o(dev_rst_n_o), .bus_mux_strap_o(mux_s),
        .width_strap_o(width_s), .endian_strap_o(endian_s),
        .cs_n_o(cs_n_o), .write_not_read_o(wnr_o), .oe_n_o(oe_n_o),
        .low_addr_or_latch_o(la_o), .addr_o(addr_o), .data_i(bus),
        .data_o(data_o), .data_oe_o(data_oe_o), .dev_irq_i(dev_irq));

    host_port_model host_port_model_i (.rst_n_i(dev_rst_n_o),
        .mux_i(mux_s), .width_i(width_s), .endian_i(endian_s),
        .cs_n_i(cs_n_o), .wnr_i(wnr_o), .oe_n_i(oe_n_o), .ale_a2_i(la_o),
        .addr_i(addr_o), .bus_i(bus), .dout_o(dout), .doe_o(doe),
        .ev_i(ev), .irq_o(dev_irq));

    // ========================================
    // Released halves show a toggling pattern, never a stale value
    assign bus[15:0] = data_oe_o ? data_o[15:0] :
        doe[0] ? dout[15:0] : idle_r[15:0];
    assign bus[31:16] = data_oe_o ? data_o[31:16] :
        doe[1] ? dout[31:16] : idle_r[31:16];

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        idle_r <= ~idle_r;
        if (data_oe_o === 1'b1 && doe[0] === 1'b1) check(32'h1, 32'h0);
    end

    // ========================================
    // Shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // No cycle count assumed; a slave that never answers meets the watchdog
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Poll busy until the sequencer is idle; a stuck one meets the watchdog
    task wait_idle;
        do begin
            apb(1'b0, 8'h10, 32'h0);
        end while (rd[0] !== 1'b0);
    endtask

    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, 8'h04, {16'h0, a});
        apb(1'b1, 8'h08, d);
        apb(1'b1, 8'h00, cfg | {30'h0, w, 1'b1});
        wait_idle();
    endtask

    task irq_is(input logic e);
        @(posedge clk_i);
        check({31'h0, irq_o}, {31'h0, e});
    endtask

    // Hold the device in reset with new straps, then let it go
    task straps(input logic [31:0] c);
        cfg = c;
        apb(1'b1, 8'h00, c | 32'h4);
        apb(1'b1, 8'h00, c);
        repeat (2) @(posedge clk_i);
        check({29'h0, host_port_model_i.mux_r, host_port_model_i.wide_r,
            host_port_model_i.le_r}, {29'h0, c[3], c[4], c[5]});
    endtask

    // Write every entry before reading any, so address aliasing shows
    task sweep(input logic [31:0] keep);
        for (int i = 0; i < 4; i++) xfer(1'b1, tbl[i], {~tbl[i], tbl[i]});
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, tbl[i], 32'h0);
            rdchk(8'h0c, {~tbl[i], tbl[i]} & keep);
        end
    endtask

    task complete_run;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        complete_run();
    end

    // ========================================
    // Main sequence
    initial begin
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h0;
        pwdata_i = 32'h0;
        ev = 3'h0;
        cfg = 32'h0;
        idle_r = 32'h5a5a_a5a5;
        tbl = '{16'h0004, 16'h0010, 16'h0038, 16'h002c};
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        check({31'h0, dev_rst_n_o}, 32'h0);
        rdchk(8'h00, 32'h34);
        rdchk(8'h10, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check({er, rd[30:0]}, 32'h8000_0000);
        // Plain addressing, wide bus, little endian
        straps(32'h30);
        sweep(32'hffff_ffff);
        // Address change refused while an access runs
        apb(1'b1, 8'h04, 32'h18);
        apb(1'b1, 8'h08, 32'h600d_f00d);
        apb(1'b1, 8'h00, cfg | 32'h3);
        rdchk(8'h10, 32'h1);
        apb(1'b1, 8'h04, 32'h20);
        wait_idle();
        rdchk(8'h04, 32'h18);
        xfer(1'b0, 16'h0018, 32'h0);
        rdchk(8'h0c, 32'h600d_f00d);
        // Completion interrupt, masked and cleared
        apb(1'b1, 8'h14, 32'hf);
        apb(1'b1, 8'h18, 32'h1);
        xfer(1'b1, 16'h0000, 32'h1);
        irq_is(1'b1);
        rdchk(8'h14, 32'h1);
        apb(1'b1, 8'h18, 32'h0);
        irq_is(1'b0);
        apb(1'b1, 8'h14, 32'h1);
        rdchk(8'h14, 32'h0);
        // Each device interrupt line in turn
        apb(1'b1, 8'h18, 32'he);
        for (int k = 0; k < 3; k++) begin
            ev[k] <= 1'b1;
            repeat (5) @(posedge clk_i);
            rdchk(8'h14, 32'h2 << k);
            irq_is(1'b1);
            apb(1'b1, 8'h14, 32'h2 << k);
            irq_is(1'b0);
        end
        ev <= 3'h0;
        // Multiplexed, wide; then narrow bus in both address modes
        straps(32'h38);
        sweep(32'hffff_ffff);
        straps(32'h00);
        sweep(32'h0000_ffff);
        straps(32'h08);
        sweep(32'h0000_ffff);
        complete_run();
    end
endmodule

/* File: logic/phb_defs.svh */
// Named constants for the parallel host bus controller.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PHB_DEFS_SVH
`define PHB_DEFS_SVH

// ========================================
// Register offsets (APB byte addresses)
`define PHB_OFS_CTRL 8'h00
`define PHB_OFS_ADDR 8'h04
`define PHB_OFS_WDATA 8'h08
`define PHB_OFS_RDATA 8'h0c
`define PHB_OFS_STATUS 8'h10
`define PHB_OFS_ISTAT 8'h14
`define PHB_OFS_IMASK 8'h18

// ========================================
// Control, status and interrupt fields
`define PHB_CTRL_START 0
`define PHB_CTRL_WRITE 1
`define PHB_CTRL_DEVRST 2
`define PHB_CTRL_MUX 3
`define PHB_CTRL_WIDTH 4
`define PHB_CTRL_ENDIAN 5
`define PHB_CTRL_MSB 5
`define PHB_CTRL_RST 6'h34
`define PHB_STAT_BUSY 0
`define PHB_IRQ_DONE 0
`define PHB_IRQ_DEV 1
`define PHB_IRQ_N 4
`define PHB_DEV_IRQ_N 3

// ========================================
// Address and data layout
`define PHB_ADDR_LO 2
`define PHB_ADDR_HI 15
`define PHB_ABIT4 4
`define PHB_DATA_W 32
`define PHB_HALF_W 16

// ========================================
// Timing, figures in ns, counts in cycles rounded up
`define PHB_CLK_NS 5
`define PHB_T_SU_NS 10
`define PHB_T_STRB_NS 30
`define PHB_T_HOLD_NS 10
`define PHB_CYC(ns) (((ns) + `PHB_CLK_NS - 1) / `PHB_CLK_NS)
`define PHB_SU_CYC `PHB_CYC(`PHB_T_SU_NS)
`define PHB_STRB_CYC `PHB_CYC(`PHB_T_STRB_NS)
`define PHB_HOLD_CYC `PHB_CYC(`PHB_T_HOLD_NS)
`define PHB_SYNC_CYC 2
`define PHB_CNT_W 4

`endif

/* File: logic/phb_host_ctrl.sv */
// Host-side controller for the device's asynchronous parallel host port.
// Assumes an APB master on clk_i and the device pins on external pads.
// Summary of operation
// - The device drives data only while output enable is low, so the host releases data then.
// - Write_not_read is low for a write cycle and high for a read cycle.
// - Without multiplexing the address pins are valid when chip select falls.
// - With the mux strap at 1 the lowest address pin is the address latch strobe.
// - Every access ends with chip select rising.
`timescale 1ns/1ps

`include "phb_defs.svh"

module phb_host_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    // Device reset and straps
    output logic dev_rst_n_o,
    output logic bus_mux_strap_o,
    output logic width_strap_o,
    output logic endian_strap_o,
    // Device bus strobes and address
    output logic cs_n_o,
    output logic write_not_read_o,
    output logic oe_n_o,
    output logic low_addr_or_latch_o,
    output logic [`PHB_ADDR_HI:`PHB_ADDR_LO+1] addr_o,
    // Shared data pins
    input wire logic [`PHB_DATA_W-1:0] data_i,
    output logic [`PHB_DATA_W-1:0] data_o,
    output logic data_oe_o,
    // Device interrupt lines
    input wire logic [`PHB_DEV_IRQ_N-1:0] dev_irq_i
);

    // ========================================
    // Declarations
    localparam logic [`PHB_CNT_W-1:0] SU_N = `PHB_CNT_W'(`PHB_SU_CYC - 1);
    localparam logic [`PHB_CNT_W-1:0] HOLD_N = `PHB_CNT_W'(`PHB_HOLD_CYC - 1);
    localparam logic [`PHB_CNT_W-1:0] WR_N = `PHB_CNT_W'(`PHB_STRB_CYC - 1);
    localparam logic [`PHB_CNT_W-1:0] RD_N =
        `PHB_CNT_W'(`PHB_STRB_CYC + `PHB_SYNC_CYC - 1);

    phb_pkg::seq_e st_r, st_nxt;
    phb_pkg::pins_s pins_r, pins_nxt;
    logic [`PHB_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic [`PHB_CTRL_MSB:0] ctrl_r, ctrl_nxt;
    logic [`PHB_ADDR_HI:`PHB_ADDR_LO] addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [`PHB_IRQ_N-1:0] istat_r, istat_nxt, imask_r, imask_nxt, ev;
    logic [2:0] strap_r, strap_nxt;
    logic devrst_n_r, devrst_n_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [`PHB_DATA_W-1:0] data_s;
    logic [`PHB_DEV_IRQ_N-1:0] dirq_s, dirq_q;
    logic busy, wr_en, go_strb, is_wr, wide;

    // ========================================
    // Input synchronisers for pins from the device
    phb_sync #(.W(`PHB_DATA_W + `PHB_DEV_IRQ_N)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({data_i, dev_irq_i}),
        .q_o({data_s, dirq_s})
    );

    // One event per rising edge of each device interrupt line
    genvar g;
    generate
        for (g = 0; g < `PHB_DEV_IRQ_N; g++) begin : g_ev
            assign ev[`PHB_IRQ_DEV+g] = dirq_s[g] & ~dirq_q[g];
        end
    endgenerate
    assign ev[`PHB_IRQ_DONE] = done_r;

    assign busy = ~st_r[0];
    assign wr_en = psel_i & penable_i & pready_r & pwrite_i;
    assign is_wr = ctrl_r[`PHB_CTRL_WRITE];
    assign wide = strap_r[1];

    // ========================================
    // Register file, straps and interrupt next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        ctrl_nxt[`PHB_CTRL_START] = 1'b0;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        imask_nxt = imask_r;
        istat_nxt = istat_r | ev;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt = psel_i & ~penable_i & ~pready_r;
        if (wr_en) begin
            unique case (paddr_i)
                `PHB_OFS_CTRL: begin
                    // Start is refused while busy or with the device in reset
                    ctrl_nxt = pwdata_i[`PHB_CTRL_MSB:0];
                    ctrl_nxt[`PHB_CTRL_START] = pwdata_i[`PHB_CTRL_START] &
                        ~busy & ~pwdata_i[`PHB_CTRL_DEVRST];
                    if (busy) begin
                        ctrl_nxt[`PHB_CTRL_WRITE] = ctrl_r[`PHB_CTRL_WRITE];
                    end
                end
                `PHB_OFS_ADDR: begin
                    if (!busy) begin
                        addr_nxt = pwdata_i[`PHB_ADDR_HI:`PHB_ADDR_LO];
                    end
                end
                `PHB_OFS_WDATA: begin
                    if (!busy) begin
                        wdata_nxt = pwdata_i;
                    end
                end
                `PHB_OFS_ISTAT: begin
                    // New events win over the clear
                    istat_nxt = (istat_r & ~pwdata_i[`PHB_IRQ_N-1:0]) | ev;
                end
                `PHB_OFS_IMASK: imask_nxt = pwdata_i[`PHB_IRQ_N-1:0];
                default: ;
            endcase
        end
        if (pready_nxt) begin
            pslverr_nxt = 1'b0;
            unique case (paddr_i)
                `PHB_OFS_CTRL: prdata_nxt = 32'(ctrl_r);
                `PHB_OFS_ADDR: prdata_nxt = {16'h0, addr_r, 2'h0};
                `PHB_OFS_WDATA: prdata_nxt = wdata_r;
                `PHB_OFS_RDATA: prdata_nxt = rdata_r;
                `PHB_OFS_STATUS: prdata_nxt = 32'(busy);
                `PHB_OFS_ISTAT: prdata_nxt = 32'(istat_r);
                `PHB_OFS_IMASK: prdata_nxt = 32'(imask_r);
                default: begin
                    prdata_nxt = 32'h0;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        // Straps follow control only while the device is held in reset
        strap_nxt = strap_r;
        if (ctrl_r[`PHB_CTRL_DEVRST]) begin
            strap_nxt = {ctrl_r[`PHB_CTRL_ENDIAN], ctrl_r[`PHB_CTRL_WIDTH],
                ctrl_r[`PHB_CTRL_MUX]};
        end
        devrst_n_nxt = ~ctrl_nxt[`PHB_CTRL_DEVRST];
        irq_nxt = |(istat_nxt & imask_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_r <= `PHB_CTRL_RST;
            addr_r <= '0;
            wdata_r <= 32'h0;
            istat_r <= '0;
            imask_r <= '0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            strap_r <= 3'h0;
            devrst_n_r <= 1'b0;
            irq_r <= 1'b0;
            dirq_q <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            strap_r <= strap_nxt;
            devrst_n_r <= devrst_n_nxt;
            irq_r <= irq_nxt;
            dirq_q <= dirq_s;
        end
    end

    // ========================================
    // Cycle sequencer next values
    always_comb begin
        st_nxt = st_r;
        pins_nxt = pins_r;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        go_strb = 1'b0;
        cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
        unique case (st_r)
            phb_pkg::ST_IDLE: begin
                if (ctrl_r[`PHB_CTRL_START]) begin
                    pins_nxt.wnr = ~is_wr;
                    cnt_nxt = SU_N;
                    if (strap_r[0]) begin
                        // Address rides the shared pins at equal index
                        st_nxt = phb_pkg::ST_ALE;
                        pins_nxt.ale_a2 = 1'b1;
                        pins_nxt.addr = '0;
                        pins_nxt.dout = {16'h0, addr_r, 2'h0};
                        pins_nxt.doe = 1'b1;
                    end else begin
                        st_nxt = phb_pkg::ST_ADDR;
                        pins_nxt.ale_a2 = addr_r[`PHB_ADDR_LO];
                        pins_nxt.addr =
                            addr_r[`PHB_ADDR_HI:`PHB_ADDR_LO+1];
                    end
                end
            end
            phb_pkg::ST_ALE: begin
                if (cnt_r == '0) begin
                    st_nxt = phb_pkg::ST_ALAT;
                    pins_nxt.ale_a2 = 1'b0;
                    cnt_nxt = HOLD_N;
                end
            end
            phb_pkg::ST_ALAT: go_strb = (cnt_r == '0);
            phb_pkg::ST_ADDR: go_strb = (cnt_r == '0);
            phb_pkg::ST_STRB: begin
                if (cnt_r == '0) begin
                    if (!is_wr) begin
                        rdata_nxt = wide ? data_s : {16'h0, data_s[15:0]};
                    end
                    st_nxt = phb_pkg::ST_HOLD;
                    pins_nxt.cs_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    cnt_nxt = HOLD_N;
                end
            end
            phb_pkg::ST_HOLD: begin
                if (cnt_r == '0) begin
                    st_nxt = phb_pkg::ST_IDLE;
                    pins_nxt.doe = 1'b0;
                    pins_nxt.wnr = 1'b1;
                    pins_nxt.ale_a2 = 1'b0;
                    done_nxt = 1'b1;
                end
            end
            default: st_nxt = phb_pkg::ST_IDLE;
        endcase
        // Data phase; a read lets go of the pins as output enable falls
        if (go_strb) begin
            st_nxt = phb_pkg::ST_STRB;
            pins_nxt.cs_n = 1'b0;
            pins_nxt.doe = is_wr;
            pins_nxt.oe_n = is_wr;
            pins_nxt.dout = wide ? wdata_r : {16'h0, wdata_r[15:0]};
            cnt_nxt = is_wr ? WR_N : RD_N;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_r <= phb_pkg::ST_IDLE;
            pins_r <= '{cs_n: 1'b1, wnr: 1'b1, oe_n: 1'b1, default: '0};
            cnt_r <= '0;
            rdata_r <= 32'h0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pins_r <= pins_nxt;
            cnt_r <= cnt_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
        end
    end

    // ========================================
    // Outputs
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign irq_o = irq_r;
    assign dev_rst_n_o = devrst_n_r;
    assign {endian_strap_o, width_strap_o, bus_mux_strap_o} = strap_r;
    assign cs_n_o = pins_r.cs_n;
    assign write_not_read_o = pins_r.wnr;
    assign oe_n_o = pins_r.oe_n;
    assign low_addr_or_latch_o = pins_r.ale_a2;
    assign addr_o = pins_r.addr;
    assign data_o = pins_r.dout;
    assign data_oe_o = pins_r.doe;

    // ========================================
    // Checks
    a_oe_no_drive: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !oe_n_o |-> !data_oe_o) else $error("data driven while oe low");
    a_dir_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !cs_n_o |-> (write_not_read_o == !is_wr))
        else $error("direction pin wrong");
    a_addr_at_cs: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(cs_n_o) && !strap_r[0] |->
        addr_o == addr_r[`PHB_ADDR_HI:`PHB_ADDR_LO+1] && $stable(addr_o))
        else $error("address not valid at cs fall");
    a_mux_addr_pins: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(low_addr_or_latch_o) && strap_r[0] |->
        data_oe_o && data_o[`PHB_ADDR_HI:`PHB_ADDR_LO] == addr_r)
        else $error("mux address not on shared pins");
    a_ale_before_cs: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(cs_n_o) && strap_r[0] |->
        !low_addr_or_latch_o && $past(!low_addr_or_latch_o, `PHB_HOLD_CYC))
        else $error("latch strobe not low before cs");
    a_bit4_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        strap_r[0] |-> !addr_o[`PHB_ABIT4]) else $error("bit4 line used in mux");
    a_cs_ends: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(cs_n_o) |-> ##[1:`PHB_HOLD_CYC] done_r)
        else $error("access not ended after cs rise");
    a_strap_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dev_rst_n_o && $past(dev_rst_n_o) |-> $stable(strap_r))
        else $error("straps moved outside reset");
    a_irq_event: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(dirq_s[0]) |=> istat_r[`PHB_IRQ_DEV])
        else $error("device interrupt lost");

endmodule

/* File: logic/phb_pkg.sv */
// Types shared by the parallel host bus controller.
// Assumes phb_defs.svh is on the include path.
`include "phb_defs.svh"

package phb_pkg;

    // ========================================
    // Cycle sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ALE  = 6'h02,
        ST_ALAT = 6'h04,
        ST_ADDR = 6'h08,
        ST_STRB = 6'h10,
        ST_HOLD = 6'h20
    } seq_e;

    // ========================================
    // Pins driven toward the device
    typedef struct packed {
        logic cs_n;
        logic wnr;
        logic oe_n;
        logic ale_a2;
        logic [`PHB_ADDR_HI:`PHB_ADDR_LO+1] addr;
        logic [`PHB_DATA_W-1:0] dout;
        logic doe;
    } pins_s;

endpackage

/* File: logic/phb_sync.sv */
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is sampled as a level; no word coherence is given.
`timescale 1ns/1ps

module phb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule
